// File: hdl/ccdts_cfg.svh
// ccdts_cfg.svh: constants and timing counts of the acquisition timing sequencer
// assumes a 50 MHz system clock; included by bare name
// Behaviour
// [RQ1] free run: open shutter right after readout
// [RQ2] free run ignores the trigger input
// [RQ3] sync output selects readout-idle or shutter-open
// [RQ4] readout-idle high except while reading out
// [RQ5] shutter-open high from activation until closed
// [RQ6] triggered modes start on selected edge polarity
// [RQ7] normal shutter: trigger, expose, close, read
// [RQ8] equipment leads signal by shutter open time
// [RQ9] early open: open when ready, trigger starts exposure
// [RQ10] early open: reopen after readout, await trigger
// [RQ11] trigger active at readout end may retrigger
// [RQ12] normal clean after enable, before acquisition
// [RQ13] continuous cleans from start until trigger
// [RQ14] trigger finishes current row shift, then collects
// [RQ15] trigger during row shift held pending
// [RQ16] latency about one vertical shift period
// [RQ17] early open keeps shutter open while cleaning
// [RQ18] continuous cleans reuse normal clean parameters
// [RQ19] hardware paced: one start, all frames
// [RQ20] host paced: host stops, restarts after processing
// [RQ21] host paced: no new frame before restart
// [RQ22] early open only in triggered modes
// [RQ23] shutter disable holds shutter open or closed
// [RQ24] no shutter: compensation interval zero
// [RQ25] exposure counter loaded at shutter opening (loaded on entering EXPOSE, so at the trigger with early open)
`ifndef CCDTS_CFG_SVH
`define CCDTS_CFG_SVH

`define CCDTS_CLK_HZ        50000000
`define CCDTS_CNT_W         32
`define CCDTS_ROWS_W        16

// timing mode codes
`define CCDTS_MODE_FREE     2'h0
`define CCDTS_MODE_SYNC     2'h1
`define CCDTS_MODE_SYNC_CC  2'h2

// shutter option codes
`define CCDTS_SHUT_NORMAL   2'h0
`define CCDTS_SHUT_EARLY    2'h1
`define CCDTS_SHUT_DIS_OPEN 2'h2
`define CCDTS_SHUT_DIS_SHUT 2'h3

// default row shift time in ns and its cycle count (rounded down, 50 cycles at 50 MHz)
`define CCDTS_ROW_SHIFT_NS  1000
`define CCDTS_ROW_SHIFT_CYC ((`CCDTS_ROW_SHIFT_NS * (`CCDTS_CLK_HZ / 1000000)) / 1000)

`endif

// File: hdl/ccdts_pkg.sv
// ccdts_pkg.sv: types of the acquisition timing sequencer
// assumes ccdts_cfg.svh holds the numeric constants
package ccdts_pkg;

  typedef enum logic [3:0] {
    IDLE,
    CLEAN,
    READY,
    CONT_CLEAN,
    EXPOSE,
    COMPENSATE,
    READOUT,
    HOLD
  } ccdts_state_e;

endpackage

// File: hdl/ccdts_shift_if.sv
// ccdts_shift_if.sv: row shift request and completion between sequencer and shifter
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface ccdts_shift_if;
  logic        start;
  logic [15:0] rows;
  logic        busy;
  logic        row_done;
  logic        done;
  logic        halt;
  modport seq (output start, output rows, output halt, input busy, input row_done, input done);
  modport shf (input start, input rows, input halt, output busy, output row_done, output done);
endinterface
`default_nettype wire

// File: hdl/ccdts_row_shifter.sv
// ccdts_row_shifter.sv: counts a burst of vertical row shifts of fixed period
// assumes start is a one-cycle pulse taken only while idle
`timescale 1ns/1ps
`default_nettype none
`include "ccdts_cfg.svh"
module ccdts_row_shifter #(
  parameter int unsigned SHIFT_CYC = `CCDTS_ROW_SHIFT_CYC
) (
  input  wire logic     clk,
  input  wire logic     rst,
  ccdts_shift_if.shf    sh
);

  logic [15:0] row_q;
  logic [15:0] tick_q;
  logic        busy_q;
  logic        last_tick;

  assign last_tick   = (tick_q == 16'(SHIFT_CYC - 1));
  assign sh.busy     = busy_q;
  assign sh.row_done = busy_q & last_tick;
  assign sh.done     = busy_q & last_tick & (row_q == 16'h0001);

  // each row completes before the next one is considered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      row_q  <= 16'h0000;
      tick_q <= 16'h0000;
    end
    else if (!busy_q)
    begin
      tick_q <= 16'h0000;
      if (sh.start && sh.rows != 16'h0000)
      begin
        busy_q <= 1'b1;
        row_q  <= sh.rows;
      end
    end
    else if (last_tick)
    begin
      tick_q <= 16'h0000;
      row_q  <= row_q - 16'h0001;
      if (row_q == 16'h0001 || sh.halt)
        busy_q <= 1'b0;
    end
    else
      tick_q <= tick_q + 16'h0001;
  end

endmodule
`default_nettype wire

// File: hdl/ccdts_sequencer.sv
// ccdts_sequencer.sv: acquisition timing sequencer top, clean, expose and readout
// assumes all inputs synchronous to CLK and configuration held steady while acquiring
`timescale 1ns/1ps
`default_nettype none
`include "ccdts_cfg.svh"
module ccdts_sequencer #(
  parameter int unsigned SHIFT_CYC = `CCDTS_ROW_SHIFT_CYC
) (
  input  wire logic                     CLK,
  input  wire logic                     SYS_RST,
  input  wire logic                     ENABLE,
  input  wire logic                     START_ACQ,
  input  wire logic                     STOP_ACQ,
  input  wire logic [1:0]               TIMING_MODE,
  input  wire logic [1:0]               SHUTTER_OPT,
  input  wire logic                     SHUTTER_FITTED,
  input  wire logic                     TRIG_RISING,
  input  wire logic                     HOST_PACED,
  input  wire logic                     SYNC_SEL_SHUTTER,
  input  wire logic                     EXT_TRIG,
  input  wire logic [`CCDTS_CNT_W-1:0]  EXPOSURE_CYC,
  input  wire logic [`CCDTS_CNT_W-1:0]  COMP_CYC,
  input  wire logic [`CCDTS_ROWS_W-1:0] CLEAN_ROWS,
  input  wire logic [`CCDTS_ROWS_W-1:0] READ_ROWS,
  output logic                          SHUTTER_OPEN,
  output logic                          READOUT_IDLE,
  output logic                          SYNC_OUT,
  output logic                          FRAME_DONE,
  output logic                          ACQ_ACTIVE,
  output logic                          READY_FLAG
);

  ccdts_shift_if sh ();

  ccdts_pkg::ccdts_state_e state_q;
  ccdts_pkg::ccdts_state_e state_d;

  // local names of the package states
  localparam ccdts_pkg::ccdts_state_e IDLE       = ccdts_pkg::IDLE;
  localparam ccdts_pkg::ccdts_state_e CLEAN      = ccdts_pkg::CLEAN;
  localparam ccdts_pkg::ccdts_state_e READY      = ccdts_pkg::READY;
  localparam ccdts_pkg::ccdts_state_e CONT_CLEAN = ccdts_pkg::CONT_CLEAN;
  localparam ccdts_pkg::ccdts_state_e EXPOSE     = ccdts_pkg::EXPOSE;
  localparam ccdts_pkg::ccdts_state_e COMPENSATE = ccdts_pkg::COMPENSATE;
  localparam ccdts_pkg::ccdts_state_e READOUT    = ccdts_pkg::READOUT;
  localparam ccdts_pkg::ccdts_state_e HOLD       = ccdts_pkg::HOLD;

  logic [`CCDTS_CNT_W-1:0] cnt_q;
  logic                    trig_q;
  logic                    pend_q;
  logic                    acq_q;
  logic                    cleaned_q;
  logic                    shut_q;
  logic                    idle_q;
  logic                    sync_q;
  logic                    fdone_q;
  logic                    rdy_q;
  logic                    edge_now;
  logic                    trig_act;
  logic                    triggered;
  logic                    early;
  logic                    cnt_zero;
  logic                    shutter_d;
  logic                    start_clean;
  logic                    start_read;
  logic                    cc_mode;
  logic                    halt_clean;

  ccdts_row_shifter #(
    .SHIFT_CYC (SHIFT_CYC)
  ) u_shift (
    .clk (CLK),
    .rst (SYS_RST),
    .sh  (sh.shf)
  );

  // mode decode; code 3 runs as plain triggered
  always_comb
  begin
    triggered = 1'b1;
    cc_mode   = 1'b0;
    case (TIMING_MODE)
      `CCDTS_MODE_FREE:
        triggered = 1'b0;
      `CCDTS_MODE_SYNC_CC:
        cc_mode = 1'b1;
      default:
        triggered = 1'b1;
    endcase
    // early open honoured only in triggered modes
    early = triggered && (SHUTTER_OPT == `CCDTS_SHUT_EARLY); // [RQ22]
  end

  // active level and edge follow the selected polarity
  always_comb
  begin
    if (TRIG_RISING)
    begin
      trig_act = EXT_TRIG;
      edge_now = EXT_TRIG & ~trig_q; // [RQ6]
    end
    else
    begin
      trig_act = ~EXT_TRIG;
      edge_now = ~EXT_TRIG & trig_q; // [RQ6]
    end
  end

  assign cnt_zero  = (cnt_q == '0);

  // trigger history register
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      trig_q <= 1'b0;
    else
      trig_q <= EXT_TRIG;
  end

  // acquisition run flag: start sets, stop clears, start wins
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      acq_q <= 1'b0;
    else if (!ENABLE)
      acq_q <= 1'b0;
    else if (START_ACQ)
      acq_q <= 1'b1;
    else if (STOP_ACQ)
      acq_q <= 1'b0; // [RQ20]
  end

  // pending trigger; in free run nothing is latched; clear wins over set
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      pend_q <= 1'b0;
    else if (!triggered || !acq_q)
      pend_q <= 1'b0; // [RQ2]
    else if (edge_now && (state_q == READY || state_q == CONT_CLEAN) && state_d != EXPOSE)
      pend_q <= 1'b1; // [RQ15]
    else if (state_q == READOUT && sh.done && trig_act)
      pend_q <= 1'b1; // [RQ11]
    else if (state_d == EXPOSE)
      pend_q <= 1'b0;
  end

  // normal clean after enable is remembered until disable
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      cleaned_q <= 1'b0;
    else if (!ENABLE)
      cleaned_q <= 1'b0;
    else if (state_q == CLEAN && sh.done)
      cleaned_q <= 1'b1; // [RQ12]
  end

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      IDLE:
      begin
        if (ENABLE && !cleaned_q)
          state_d = CLEAN; // [RQ12]
        else if (ENABLE && acq_q)
          state_d = cc_mode ? CONT_CLEAN : READY;
      end
      CLEAN:
      begin
        if (sh.done)
          state_d = IDLE;
      end
      READY:
      begin
        if (!acq_q)
          state_d = IDLE;
        else if (!triggered)
          state_d = EXPOSE; // [RQ1]
        else if (pend_q || edge_now)
          state_d = EXPOSE; // [RQ7]
      end
      CONT_CLEAN:
      begin
        // stop only at a row boundary or with no shift running
        if ((pend_q || edge_now) && (!sh.busy || sh.row_done))
          state_d = EXPOSE; // [RQ14] [RQ16]
        else if (!acq_q && !sh.busy)
          state_d = IDLE; // [RQ13]
      end
      EXPOSE:
      begin
        if (cnt_zero)
          state_d = COMPENSATE;
      end
      COMPENSATE:
      begin
        if (cnt_zero)
          state_d = READOUT;
      end
      READOUT:
      begin
        if (sh.done)
          state_d = HOLD;
      end
      HOLD:
      begin
        if (!ENABLE)
          state_d = IDLE;
        else if (HOST_PACED)
          state_d = acq_q ? HOLD : IDLE; // [RQ21]
        else if (!acq_q)
          state_d = IDLE;
        else
          state_d = cc_mode ? CONT_CLEAN : READY; // [RQ19]
      end
      default:
        state_d = IDLE;
    endcase
    // a frame in flight finishes before disable takes hold
    if (!ENABLE && state_q != EXPOSE && state_q != COMPENSATE && state_q != READOUT)
      state_d = IDLE;
  end

  // state register
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      state_q <= IDLE;
    else
      state_q <= state_d;
  end

  // host-paced hold waits for stop then a fresh start
  // handled by HOLD returning to IDLE only after stop clears the run flag

  // shift requests; continuous cleans use the normal clean row count
  always_comb
  begin
    start_clean = 1'b0;
    start_read  = 1'b0;
    halt_clean  = 1'b0;
    case (state_q)
      IDLE:
        start_clean = (state_d == CLEAN);
      CONT_CLEAN:
      begin
        start_clean = !sh.busy && acq_q && (state_d == CONT_CLEAN); // [RQ13] [RQ18]
        // a burst cut at a row boundary must not run into the exposure
        halt_clean  = (state_d == EXPOSE); // [RQ14]
      end
      COMPENSATE:
        start_read = cnt_zero;
      default:
        start_clean = 1'b0;
    endcase
  end

  assign sh.start = start_clean | start_read;
  assign sh.rows  = start_read ? READ_ROWS : CLEAN_ROWS; // [RQ18]
  assign sh.halt  = halt_clean;

  // exposure and compensation counter
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      cnt_q <= '0;
    else if (state_d == EXPOSE && state_q != EXPOSE)
      cnt_q <= EXPOSURE_CYC; // [RQ25]
    else if (state_q == EXPOSE && cnt_zero)
      cnt_q <= SHUTTER_FITTED ? COMP_CYC : '0; // [RQ24]
    else if (!cnt_zero)
      cnt_q <= cnt_q - 1'b1;
  end

  // shutter drive
  always_comb
  begin
    shutter_d = 1'b0;
    case (state_d)
      EXPOSE:
        shutter_d = 1'b1; // [RQ7]
      READY, CONT_CLEAN:
        shutter_d = early; // [RQ9] [RQ10] [RQ17]
      default:
        shutter_d = 1'b0;
    endcase
    if (SHUTTER_OPT == `CCDTS_SHUT_DIS_OPEN)
      shutter_d = 1'b1; // [RQ23]
    else if (SHUTTER_OPT == `CCDTS_SHUT_DIS_SHUT)
      shutter_d = 1'b0; // [RQ23]
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      shut_q <= 1'b0;
    else
      shut_q <= shutter_d; // [RQ5]
  end

  // readout idle and selectable sync output
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      idle_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      idle_q <= (state_d != READOUT); // [RQ4]
      sync_q <= SYNC_SEL_SHUTTER ? shutter_d : (state_d != READOUT); // [RQ3]
    end
  end

  // status flags
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      fdone_q <= 1'b0;
      rdy_q   <= 1'b0;
    end
    else
    begin
      fdone_q <= (state_q == READOUT) && sh.done;
      rdy_q   <= (state_d == READY) || (state_d == CONT_CLEAN);
    end
  end

  assign SHUTTER_OPEN = shut_q;
  assign READOUT_IDLE = idle_q;
  assign SYNC_OUT     = sync_q;
  assign FRAME_DONE   = fdone_q;
  assign ACQ_ACTIVE   = acq_q;
  assign READY_FLAG   = rdy_q;

endmodule
`default_nettype wire

// File: verification/ccdts_monitor.sv
// ccdts_monitor.sv: port assertions of the acquisition timing sequencer
// assumes it is bound to ccdts_sequencer with the same SHIFT_CYC
`timescale 1ns/1ps
`default_nettype none
module ccdts_monitor #(
  parameter int unsigned SHIFT_CYC = 2
) (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic [1:0]  TIMING_MODE,
  input wire logic [1:0]  SHUTTER_OPT,
  input wire logic        TRIG_RISING,
  input wire logic        SYNC_SEL_SHUTTER,
  input wire logic        EXT_TRIG,
  input wire logic [31:0] EXPOSURE_CYC,
  input wire logic [15:0] READ_ROWS,
  input wire logic        SHUTTER_OPEN,
  input wire logic        READOUT_IDLE,
  input wire logic        SYNC_OUT,
  input wire logic        FRAME_DONE,
  input wire logic        READY_FLAG
);
  localparam int CC_MAX = SHIFT_CYC + 3;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic [31:0] ro_q;
  logic [31:0] sh_q;
  logic        trig_q;
  logic        src_q;
  logic        src_w;
  logic        edge_w;
  assign src_w  = SYNC_SEL_SHUTTER ? SHUTTER_OPEN : READOUT_IDLE;
  assign edge_w = TRIG_RISING ? (EXT_TRIG & ~trig_q) : (~EXT_TRIG & trig_q);
  always_ff @(posedge CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      ro_q   <= 32'h0;
      sh_q   <= 32'h0;
      trig_q <= 1'b0;
      src_q  <= 1'b1;
    end
    else
    begin
      ro_q   <= READOUT_IDLE ? 32'h0 : ro_q + 32'h1;
      sh_q   <= SHUTTER_OPEN ? sh_q + 32'h1 : 32'h0;
      trig_q <= EXT_TRIG;
      src_q  <= src_w;
    end
  ro_len_a: assert property ($rose(READOUT_IDLE) |-> ro_q == READ_ROWS * SHIFT_CYC)
    else $error("readout length wrong");
  exp_len_a: assert property ($fell(SHUTTER_OPEN) && SHUTTER_OPT == 2'h0 |-> sh_q == EXPOSURE_CYC + 32'h1)
    else $error("exposure length wrong");
  shut_read_a: assert property (SHUTTER_OPT != 2'h2 |-> !(SHUTTER_OPEN && !READOUT_IDLE))
    else $error("shutter open during readout");
  dis_shut_a: assert property (SHUTTER_OPT == 2'h3 && $past(SHUTTER_OPT) == 2'h3 |-> !SHUTTER_OPEN)
    else $error("disabled shutter opened");
  sync_src_a: assert property ($stable(SYNC_SEL_SHUTTER) |-> SYNC_OUT == src_w || SYNC_OUT == src_q)
    else $error("sync output source wrong");
  done_pulse_a: assert property (FRAME_DONE |-> READOUT_IDLE ##1 !FRAME_DONE)
    else $error("frame done not a pulse");
  trig_open_a: assert property (edge_w && READY_FLAG && TIMING_MODE == 2'h1 && SHUTTER_OPT == 2'h0
    |-> ##[1:2] SHUTTER_OPEN)
    else $error("trigger did not open shutter");
  cc_lat_a: assert property (edge_w && READY_FLAG && TIMING_MODE == 2'h2 |-> ##[1:CC_MAX] !READY_FLAG)
    else $error("cleaning trigger latency too long");
  early_a: assert property (READY_FLAG && $past(READY_FLAG) && SHUTTER_OPT == 2'h1 && TIMING_MODE != 2'h0
    |-> SHUTTER_OPEN)
    else $error("early open shutter closed while waiting");
endmodule
bind ccdts_sequencer ccdts_monitor #(.SHIFT_CYC(SHIFT_CYC)) u_mon (.*);
`default_nettype wire

// File: verification/ccdts_host_model.sv
// ccdts_host_model.sv: host commands and trigger equipment
// assumes requests from the bench are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module ccdts_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic act_rising,
  input  wire logic host_paced,
  input  wire logic frame_done,
  input  wire logic start_req,
  input  wire logic stop_req,
  input  wire logic trig_req,
  output var logic  start_acq,
  output var logic  stop_acq,
  output logic      ext_trig
);
  logic [1:0] hold_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      start_acq <= 1'b0;
      stop_acq  <= 1'b0;
    end
    else
    begin
      start_acq <= start_req;
      stop_acq  <= stop_req | (host_paced & frame_done);
    end
  // active edge first, released long before readout ends
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hold_q <= 2'h0;
    else if (trig_req)
      hold_q <= 2'h3;
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  assign ext_trig = act_rising ~^ (hold_q != 2'h0);
endmodule
`default_nettype wire

// File: verification/tb.sv
// tb.sv: self-checking bench of the acquisition timing sequencer
// assumes ccdts_monitor is bound to the design
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        ENABLE = 1'b0;
  logic [1:0]  TIMING_MODE = 2'h1;
  logic [1:0]  SHUTTER_OPT = 2'h0;
  logic        SHUTTER_FITTED = 1'b1;
  logic        TRIG_RISING = 1'b0;
  logic        HOST_PACED = 1'b0;
  logic        SYNC_SEL_SHUTTER = 1'b0;
  logic [31:0] EXPOSURE_CYC = 32'h5;
  logic [31:0] COMP_CYC = 32'h3;
  logic [15:0] CLEAN_ROWS = 16'h3;
  logic [15:0] READ_ROWS = 16'h4;
  logic        start_req = 1'b0;
  logic        stop_req = 1'b0;
  logic        trig_req = 1'b0;
  logic        START_ACQ, STOP_ACQ, EXT_TRIG, SHUTTER_OPEN, READOUT_IDLE;
  logic        SYNC_OUT, FRAME_DONE, ACQ_ACTIVE, READY_FLAG;
  int          err_total = 0;
  int          n_compared = 0;
  ccdts_sequencer #(.SHIFT_CYC(2)) DUT (.*);
  ccdts_host_model u_host (.clk(CLK), .rst(SYS_RST), .act_rising(TRIG_RISING), .host_paced(HOST_PACED),
    .frame_done(FRAME_DONE), .start_req(start_req), .stop_req(stop_req), .trig_req(trig_req),
    .start_acq(START_ACQ), .stop_acq(STOP_ACQ), .ext_trig(EXT_TRIG));
  initial
    forever #10 CLK = ~CLK;
  task automatic close_out();
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // k: bit 0 start, bit 1 stop, bit 2 trigger
  task automatic go(input logic [2:0] k);
    @(posedge CLK);
    start_req <= k[0];
    stop_req  <= k[1];
    trig_req  <= k[2];
    @(posedge CLK);
    start_req <= 1'b0;
    stop_req  <= 1'b0;
    trig_req  <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return FRAME_DONE;
      1: return READY_FLAG;
      default: return SHUTTER_OPEN;
    endcase
  endfunction
  task automatic wait_sig(input int s, input logic v, input string nm);
    int i;
    @(negedge CLK);
    for (i = 0; i < 400 && pick(s) !== v; i++)
      @(negedge CLK);
    chk(nm, v, pick(s));
  endtask
  task automatic idle_for(input int n);
    repeat (n) @(negedge CLK);
  endtask
  initial
  begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    ENABLE  <= 1'b1;
    idle_for(30);
    go(3'h1);
    wait_sig(1, 1'b1, "ready");
    go(3'h4);
    idle_for(1);
    chk("shutter", 1'b0, SHUTTER_OPEN);
    wait_sig(2, 1'b1, "shutter");
    chk("sync_out", 1'b1, SYNC_OUT);
    wait_sig(0, 1'b1, "frame_done");
    wait_sig(1, 1'b1, "ready");
    go(3'h2);
    idle_for(4);
    TRIG_RISING      <= 1'b1;
    TIMING_MODE      <= 2'h2;
    SHUTTER_OPT      <= 2'h1;
    SYNC_SEL_SHUTTER <= 1'b1;
    go(3'h1);
    wait_sig(1, 1'b1, "ready");
    idle_for(1);
    chk("shutter", 1'b1, SHUTTER_OPEN);
    chk("sync_out", 1'b1, SYNC_OUT);
    go(3'h4);
    wait_sig(0, 1'b1, "frame_done");
    wait_sig(2, 1'b1, "shutter");
    go(3'h2);
    idle_for(4);
    TIMING_MODE <= 2'h0;
    HOST_PACED  <= 1'b1;
    go(3'h1);
    wait_sig(2, 1'b1, "shutter");
    go(3'h4);
    wait_sig(0, 1'b1, "frame_done");
    idle_for(60);
    chk("shutter", 1'b0, SHUTTER_OPEN);
    chk("readout_idle", 1'b1, READOUT_IDLE);
    SHUTTER_OPT    <= 2'h3;
    SHUTTER_FITTED <= 1'b0;
    go(3'h1);
    wait_sig(0, 1'b1, "frame_done");
    chk("shutter", 1'b0, SHUTTER_OPEN);
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge CLK);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
